// ==== core/sram_host.sv ====
// Host controller sequencing reads and writes to an async SRAM
`timescale 1ns/1ps
`include "sram_host_consts.svh"
module sram_host
  import sram_host_pkg::*;
#(
  parameter int ADDR_W = 18,
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input  wire logic              core_clk_in,
  input  wire logic              rst_b_in,
  // User request port
  input  wire logic              req_valid_in,
  input  wire logic              req_write_in,
  input  wire logic [ADDR_W-1:0] req_addr_in,
  input  wire logic [DATA_W-1:0] req_wdata_in,
  input  wire logic [1:0]        req_lanes_in,
  output logic                   req_ready_out,
  output logic                   rd_valid_out,
  output logic [DATA_W-1:0]      rd_data_out,
  // SRAM pins
  output logic [ADDR_W-1:0]      sram_addr_out,
  output logic                   chip_select_low_active_out,
  output logic                   chip_select_high_active_out,
  output logic                   write_n_out,
  output logic                   output_gate_n_out,
  output logic                   lower_lane_select_n_out,
  output logic                   upper_lane_select_n_out,
  input  wire logic [DATA_W-1:0] sram_data_in,
  output logic [DATA_W-1:0]      sram_data_out,
  output logic                   sram_data_oe_out
);
  localparam logic [4:0] RD_LAST = 5'(`RD_CYC + `RD_SYNC_CYC);
  localparam logic [4:0] WR_LAST = 5'(`WP_CYC);
  localparam logic [4:0] TN_LAST = 5'(`HZ_CYC);

  host_state_t     state_reg;       // Sequencer state
  host_state_t     state_next;      // Next state
  logic [4:0]      cnt_reg;         // Cycles spent in state
  logic [1:0]      lanes_reg;       // Latched lane enables
  logic [DATA_W-1:0] sync1_reg;     // First sync stage, data pins
  logic [DATA_W-1:0] sync2_reg;     // Second sync stage
  logic            done;            // Current phase time elapsed
  logic            take;            // Request accepted
  logic [DATA_W-1:0] lane_mask;     // Byte mask from lanes

  sram_pins_if pins ();

  // Lane to byte mapping
  function automatic logic [DATA_W-1:0] mask_of(input logic [1:0] l);
    mask_of = {{(DATA_W/2){l[1]}}, {(DATA_W/2){l[0]}}};
  endfunction : mask_of

  assign lane_mask     = mask_of(lanes_reg);
  assign req_ready_out = (state_reg == ST_IDLE);
  assign take          = req_valid_in && req_ready_out;
  assign done          = (state_reg == ST_READ  && cnt_reg == RD_LAST) ||
                         (state_reg == ST_WRITE && cnt_reg == WR_LAST) ||
                         (state_reg == ST_TURN  && cnt_reg == TN_LAST);

  // Next state decode
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE:
        if (take)
          state_next = req_write_in ? ST_WRITE : ST_READ;
      ST_READ:
        if (done)
          state_next = ST_TURN;
      ST_WRITE:
        if (done)
          state_next = ST_TURN;
      ST_TURN:
        if (done)
          state_next = ST_IDLE;
    endcase
  end

  // Pin intent; pin driver adds one flop so all strobes move together.
  // write qualified by both chip selects; not gated by the lane selects
  assign pins.cs_act = (state_reg == ST_READ) || (state_reg == ST_WRITE);
  assign pins.wr_act = (state_reg == ST_WRITE);
  assign pins.rd_act = (state_reg == ST_READ);
  // bus driven in write phase and held one edge after it
  assign pins.drive  = (state_reg == ST_WRITE);
  assign pins.lanes  = pins.cs_act ? lanes_reg : 2'b00;

  sram_pin_drv u_drv (
    .core_clk_in                 (core_clk_in),
    .rst_b_in                    (rst_b_in),
    .ctl                         (pins),
    .chip_select_low_active_out  (chip_select_low_active_out),
    .chip_select_high_active_out (chip_select_high_active_out),
    .write_n_out                 (write_n_out),
    .output_gate_n_out           (output_gate_n_out),
    .lower_lane_select_n_out     (lower_lane_select_n_out),
    .upper_lane_select_n_out     (upper_lane_select_n_out),
    .data_oe_out                 (sram_data_oe_out)
  );

  // State and phase counter
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 5'h0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= (state_next != state_reg) ? 5'h0 : cnt_reg + 5'h1;
    end
  end

  // Address and data latched at accept, stable through the cycle
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sram_addr_out <= '0;
      sram_data_out <= '0;
      lanes_reg     <= 2'b00;
    end
    else if (take)
    begin
      sram_addr_out <= req_addr_in;
      sram_data_out <= req_wdata_in;
      lanes_reg     <= req_lanes_in;
    end
  end

  // Two stage sync of the data pins before use
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= sram_data_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Capture read data at end of read phase. Data is valid a full access
  // time after the strobes land; the phase is stretched so that the
  // synchronised copy is already past that point while strobes still
  // hold the device driving. Costs three cycles per read.
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rd_valid_out <= 1'b0;
      rd_data_out  <= '0;
    end
    else
    begin
      rd_valid_out <= (state_reg == ST_READ) && done;
      if ((state_reg == ST_READ) && done)
        rd_data_out <= sync2_reg & lane_mask;
    end
  end

  AST_WR_LEN: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    $rose(pins.wr_act) |-> pins.wr_act [*8])
    else $error("write phase too short");
  AST_RD_LEN: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    $rose(pins.rd_act) |-> pins.rd_act [*8])
    else $error("read phase too short");
  AST_ADDR: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    pins.cs_act && $past(pins.cs_act) |-> $stable(sram_addr_out))
    else $error("address moved in cycle");
  AST_TURN: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    $fell(pins.cs_act) |-> !pins.cs_act [*5])
    else $error("turnaround too short");
  AST_CS_WR: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    pins.wr_act |-> pins.cs_act && pins.drive)
    else $error("write without select");
  AST_LANE: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    (pins.lanes != 2'b00) |-> pins.cs_act)
    else $error("lane without select");
  AST_RDV: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    rd_valid_out |-> $past(state_reg) == ST_READ)
    else $error("read valid out of place");
  // no read and write at once
  AST_EXCL: assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    !(pins.wr_act && pins.rd_act))
    else $error("read and write overlap");
  // bus held one edge past strobe release
  sequence drive_tail;
    sram_data_oe_out ##1 !sram_data_oe_out;
  endsequence
  AST_DATA_HOLD: assert property (@(posedge core_clk_in)
    disable iff (!rst_b_in)
    $rose(write_n_out) |-> drive_tail)
    else $error("write data released early");
endmodule : sram_host

// ==== core/sram_host_consts.svh ====
// Timing constants for the asynchronous SRAM host controller
`ifndef SRAM_HOST_CONSTS_SVH
`define SRAM_HOST_CONSTS_SVH
`define CLK_PERIOD_NS      5
// Faster grade figures in ns
`define T_RC_NS            70
`define T_AA_NS            70
`define T_OE_NS            40
`define T_OH_NS            10
`define T_HZ_NS            25
`define T_WC_NS            70
`define T_CW_NS            60
`define T_WP_NS            50
`define T_BW_NS            55
`define T_DW_NS            30
`define T_OW_NS            5
// Cycle counts: least times round up
`define CYC_UP(ns)  (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC      `CYC_UP(`T_RC_NS)
`define WP_CYC      `CYC_UP(`T_WC_NS)
`define HZ_CYC      `CYC_UP(`T_HZ_NS)
// Read phase stretch: one edge clears the access-time race, two more
// cover the data pin synchroniser before the strobes release
`define RD_SYNC_CYC 3
`endif

// ==== core/sram_host_pkg.sv ====
// Types for the asynchronous SRAM host controller
package sram_host_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_READ,
    ST_WRITE,
    ST_TURN
  } host_state_t;
endpackage : sram_host_pkg

// ==== core/sram_pins_if.sv ====
// Pin bundle between the sequencer and the pin driver
`timescale 1ns/1ps
interface sram_pins_if;
  logic        cs_act;
  logic        wr_act;
  logic        rd_act;
  logic        drive;
  logic [1:0]  lanes;
  modport seq (output cs_act, output wr_act, output rd_act,
               output drive, output lanes);
  modport drv (input cs_act, input wr_act, input rd_act,
               input drive, input lanes);
endinterface : sram_pins_if

// ==== core/sram_pin_drv.sv ====
// Registered pin driver turning active flags into SRAM pin levels
`timescale 1ns/1ps
module sram_pin_drv
(
  // Clock and reset
  input  wire logic  core_clk_in,
  input  wire logic  rst_b_in,
  // Control bundle
  sram_pins_if.drv   ctl,
  // Pins
  output logic       chip_select_low_active_out,
  output logic       chip_select_high_active_out,
  output logic       write_n_out,
  output logic       output_gate_n_out,
  output logic       lower_lane_select_n_out,
  output logic       upper_lane_select_n_out,
  output logic       data_oe_out
);
  // All strobes from flops so they switch glitch free
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      chip_select_low_active_out  <= 1'b1;
      chip_select_high_active_out <= 1'b0;
      write_n_out                 <= 1'b1;
      output_gate_n_out           <= 1'b1;
      lower_lane_select_n_out     <= 1'b1;
      upper_lane_select_n_out     <= 1'b1;
      data_oe_out                 <= 1'b0;
    end
    else
    begin
      chip_select_low_active_out  <= ~ctl.cs_act;
      chip_select_high_active_out <= ctl.cs_act;
      write_n_out                 <= ~ctl.wr_act;
      output_gate_n_out           <= ~ctl.rd_act;
      lower_lane_select_n_out     <= ~ctl.lanes[0];
      upper_lane_select_n_out     <= ~ctl.lanes[1];
      // data outlives strobe one edge; output gate stays high
      // in writes, so the far side never drives into the held bus
      data_oe_out                 <= ctl.drive || !write_n_out;
    end
  end
endmodule : sram_pin_drv

// ==== bench/sram_dev_model.sv ====
// Behavioural async SRAM answering the host controller
`timescale 1ns/1ps
module sram_dev_model
(
  // Pins from the host
  input  wire logic [17:0] addr_in,
  input  wire logic        chip_select_low_active_in,
  input  wire logic        chip_select_high_active_in,
  input  wire logic        write_n_in,
  input  wire logic        output_gate_n_in,
  input  wire logic        lower_lane_select_n_in,
  input  wire logic        upper_lane_select_n_in,
  input  wire logic [15:0] wdata_in,
  // Data toward the host
  output logic      [15:0] rdata_out
);
  logic [15:0] mem [0:262143];  // Storage array
  logic [15:0] wbuf;            // Data seen inside the write window
  logic [17:0] abuf;            // Address seen inside the write window
  logic [1:0]  lbuf;            // Lanes seen inside the write window
  logic        valid = 1'b0;    // Access time has run out
  int          stamp = 0;       // Bumps on every access change
  wire         any_lane = !(lower_lane_select_n_in && upper_lane_select_n_in);
  wire         sel = !chip_select_low_active_in && chip_select_high_active_in;
  // window opens on last edge, closes on first
  wire         wr_on = sel && !write_n_in && any_lane;
  wire         rd_on = sel && write_n_in && !output_gate_n_in && any_lane;
  wire  [15:0] word = mem[addr_in];
  // Capture continuously, since lanes drop on the closing edge; the
  // pins are tested directly so released lane levels never get in
  always @(*)
    if (!chip_select_low_active_in && chip_select_high_active_in &&
        !write_n_in && !(lower_lane_select_n_in && upper_lane_select_n_in))
    begin
      wbuf = wdata_in;
      abuf = addr_in;
      lbuf = {upper_lane_select_n_in, lower_lane_select_n_in};
    end
  // commit each enabled byte at write end
  always @(negedge wr_on)
  begin
    if (!lbuf[0]) mem[abuf][7:0] = wbuf[7:0];
    if (!lbuf[1]) mem[abuf][15:8] = wbuf[15:8];
  end
  // worst case: data only 70 ns after change
  always @(rd_on or addr_in or lbuf or word)
  begin
    stamp = stamp + 1;
    valid = 1'b0;
    fork
      begin
        automatic int s = stamp;
        #70;
        if (s == stamp && rd_on) valid = 1'b1;
      end
    join_none
  end
  // released lanes show the inverted word, never old data
  assign rdata_out =
    {(valid && !upper_lane_select_n_in) ? word[15:8] : ~word[15:8],
     (valid && !lower_lane_select_n_in) ? word[7:0] : ~word[7:0]};
endmodule : sram_dev_model

// ==== bench/async_sram_read_write_timing_test.sv ====
// Self-checking bench for the SRAM host controller
`timescale 1ns/1ps
module async_sram_read_write_timing_test;
  logic core_clk = 1'b0, rst_b = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [17:0] req_addr = 18'h0_0000;
  logic [15:0] req_wdata = 16'h0000;
  logic [1:0]  req_lanes = 2'h0;
  logic ready, rd_valid, csl, csh, write_n, gate_n, lo_n, up_n, dq_oe;
  logic [15:0] rd_data, dq_in, dq_out;
  logic [17:0] addr, a_ws;
  real t_ws, t_prev = -100.0, t_cs, t_ln, t_d;  // Edge times
  int errors = 0;
  int n_compared = 0;
  wire wr_on = !csl && csh && !write_n && !(lo_n && up_n);
  wire rd_on = !csl && csh && write_n && !gate_n && !(lo_n && up_n);
  always #2.5 core_clk = ~core_clk;
  sram_host sram_host_i (.core_clk_in(core_clk), .rst_b_in(rst_b),
    .req_valid_in(req_valid), .req_write_in(req_write),
    .req_addr_in(req_addr), .req_wdata_in(req_wdata),
    .req_lanes_in(req_lanes), .req_ready_out(ready),
    .rd_valid_out(rd_valid), .rd_data_out(rd_data), .sram_addr_out(addr),
    .chip_select_low_active_out(csl), .chip_select_high_active_out(csh),
    .write_n_out(write_n), .output_gate_n_out(gate_n),
    .lower_lane_select_n_out(lo_n), .upper_lane_select_n_out(up_n),
    .sram_data_in(dq_in), .sram_data_out(dq_out), .sram_data_oe_out(dq_oe));
  sram_dev_model sram_dev_model_i (.addr_in(addr),
    .chip_select_low_active_in(csl), .chip_select_high_active_in(csh),
    .write_n_in(write_n), .output_gate_n_in(gate_n),
    .lower_lane_select_n_in(lo_n), .upper_lane_select_n_in(up_n),
    .wdata_in(dq_out), .rdata_out(dq_in));
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic conclude();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Edge timestamps for the write-side timing checks
  always @(negedge csl) t_cs = $realtime;
  always @(negedge lo_n or negedge up_n) t_ln = $realtime;
  always @(dq_out) t_d = $realtime;
  always @(posedge wr_on)
  begin
    check("write spacing", 1, $realtime - t_prev >= 70.0);
    t_prev = $realtime;
    t_ws = $realtime;
    a_ws = addr;
  end
  always @(negedge wr_on)
  begin
    check("pulse width", 1, $realtime - t_ws >= 50.0);
    check("select time", 1, $realtime - t_cs >= 60.0);
    check("lane time", 1, $realtime - t_ln >= 55.0);
    check("write addr", a_ws, addr);
    check("data setup", 1, $realtime - t_d >= 30.0);
    check("data held", 1, dq_oe);
  end
  // Host must never drive while the device may
  always @(negedge core_clk)
    if (rst_b) check("contention", 0, dq_oe & rd_on);
  task automatic send(input logic w, input logic [17:0] a,
                      input logic [15:0] d, input logic [1:0] l);
    int i;
    for (i = 0; i < 100 && ready !== 1'b1; i++) @(posedge core_clk) #1;
    if (i == 100) begin errors++; conclude(); end
    req_valid = 1'b1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    req_lanes = l;
    @(posedge core_clk) #1;
    req_valid = 1'b0;
  endtask : send
  task automatic read_chk(input logic [17:0] a, input logic [1:0] l,
                          input logic [15:0] exp);
    int i;
    send(1'b0, a, 16'h0000, l);
    for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(posedge core_clk) #1;
    if (i == 40) begin errors++; conclude(); end
    check("read data", exp, rd_data);
  endtask : read_chk
  task automatic sc_reset();
    check("idle pins", 8'hbd,
          {csl, csh, write_n, gate_n, lo_n, up_n, dq_oe, ready});
  endtask : sc_reset
  task automatic sc_full();
    send(1'b1, 18'h0_0001, 16'ha5c3, 2'h3);
    read_chk(18'h0_0001, 2'h3, 16'ha5c3);
  endtask : sc_full
  task automatic sc_lanes();
    send(1'b1, 18'h0_0001, 16'h1234, 2'h1);
    read_chk(18'h0_0001, 2'h3, 16'ha534);
    read_chk(18'h0_0001, 2'h2, 16'ha500);
    read_chk(18'h0_0001, 2'h1, 16'h0034);
  endtask : sc_lanes
  task automatic sc_nolane();
    send(1'b1, 18'h0_0001, 16'hffff, 2'h0);
    read_chk(18'h0_0001, 2'h3, 16'ha534);
  endtask : sc_nolane
  task automatic sc_b2b();
    send(1'b1, 18'h3_ffff, 16'h0f0f, 2'h3);
    send(1'b1, 18'h0_0000, 16'hf0f0, 2'h3);
    read_chk(18'h3_ffff, 2'h3, 16'h0f0f);
    read_chk(18'h0_0000, 2'h3, 16'hf0f0);
  endtask : sc_b2b
  initial
  begin
    repeat (10) @(posedge core_clk);
    #1;
    sc_reset();
    rst_b = 1'b1;
    sc_full();
    sc_lanes();
    sc_nolane();
    sc_b2b();
    conclude();
  end
endmodule : async_sram_read_write_timing_test
